/* File: shared/indicator_map.vh */
// Constants for the scanner status indicator
`ifndef INDICATOR_MAP_VH
`define INDICATOR_MAP_VH
`define CLK_PERIOD_NS 10
`define TICK_NS       1000000
`define BLINK_MS      250
`define RECOVER_MS    10000
`define FREE_MS       5000
`define ITEM_MS       1000
`define MS_W          14
`define ADDR_CTRL     12'h000
`define ADDR_STATUS   12'h004
`define ADDR_MASK     12'h008
`define ADDR_STATE    12'h00C
`define ADDR_ERRINFO  12'h010
`define CTRL_RST      32'h00000001
`define CTRL_DISP_EN  0
`define CTRL_LINK_LSB 1
`define EV_W          5
`define EV_ERR        0
`define EV_MSG        1
`define EV_RECOVER    2
`define EV_PING       3
`define EV_BOOT_DONE  4
`define SRC_A         2'h0
`define SRC_B         2'h1
`define SRC_DEV       2'h2
`define CLS_F         3'h0
`define CLS_E         3'h1
`define CLS_U         3'h2
`define CLS_I         3'h3
`define CLS_P         3'h4
`define CH_F          8'h46
`define CH_E          8'h45
`define CH_U          8'h55
`define CH_I          8'h49
`define CH_P          8'h50
`define CH_A          8'h41
`define CH_B          8'h42
`define CH_D          8'h44
`define CH_COLON      8'h3A
`define CH_ZERO       8'h30
`define CH_SP         8'h20
`define SCR_TYPE      4'h0
`define SCR_WIRELESS  4'h5
`define SCR_NEEDED    4'h6
`define SCR_DATE      4'h7
`define SCR_SIGN      4'h8
`define SCR_TILT      4'h9
`define SCR_FIELD     4'hA
`define SCR_WAIT      4'hB
`define SCR_XFER      4'hC
`define SCR_PING      4'hD
`define SCR_VIEW      4'hE
`define SCR_BLANK     4'hF
`define TXT_WAIT      "WAIT FOR SETUP          "
`define TXT_XFER      "SETUP LOADING           "
`define TXT_NEEDED    "SETUP NEEDED            "
`define TXT_PING      "PING "
`endif

/* File: design/status_indicator.v */
// Scanner status indicator: LEDs, text display, error views, APB registers
//
// Local design decisions: the address map and the APB interface to the registers.
`include "indicator_map.vh"

// Behaviour
// R1: LEDs 1-3 function A, 4-6 function B
// R2: Red/green: off, red, red flashing, green
// R3: Yellow: dark, flashing occupied, steady ready
// R4: Yellow steady when free and link enabled
// R5: Blue lit while warning field interrupted
// R6: Normal display shows active field pair
// R7: Unconfigured boot cycles items, then tilt
// R8: Configured boot cycles items, then field pair
// R9: Waiting and transfer messages during setup
// R10: Ping shows message with device name
// R11: Messages name source and code
// R12: Class letters F, E, U, I, P
// R13: Class letter first, then numeric code
// R14: Non-locking errors clear after 10 s
// R15: Locking errors clear only by power-up
// R16: Field free 5 s returns normal display
// R17: Object in field drops safety output pair
// R18: One common blink period for flashing
module status_indicator #(
    parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
    input  wire         MCLK,
    input  wire         SRST,
    input  wire         PSEL,
    input  wire         PENABLE,
    input  wire         PWRITE,
    input  wire [11:0]  PADDR,
    input  wire [31:0]  PWDATA,
    output reg  [31:0]  PRDATA,
    output wire         PREADY,
    output wire         PSLVERR,
    output reg          IRQ,
    input  wire [1:0]   SOP_REQ,
    input  wire [1:0]   PF_OCC,
    input  wire [1:0]   WF_OCC,
    input  wire [1:0]   RES_ACTIVE,
    input  wire [1:0]   RES_READY,
    input  wire [1:0]   RES_UNLOCK,
    input  wire [1:0]   LINK_ENABLED,
    input  wire         BOOTING,
    input  wire         CFG_STORED,
    input  wire         CFG_WAIT,
    input  wire         CFG_XFER,
    input  wire         PING,
    input  wire         MSG_SET,
    input  wire [1:0]   MSG_SRC,
    input  wire [2:0]   MSG_CLASS,
    input  wire [11:0]  MSG_CODE,
    input  wire         MSG_LOCK,
    input  wire [191:0] SRC_TEXT,
    output reg  [1:0]   SOP_OUT,
    output reg          LED1_RED,
    output reg          LED1_GRN,
    output reg          LED2,
    output reg          LED3,
    output reg          LED4,
    output reg          LED5,
    output reg          LED6_RED,
    output reg          LED6_GRN,
    output reg  [3:0]   DISP_SCREEN,
    output reg  [191:0] DISP_TEXT
);

    localparam ST_BOOT = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_VIEW = 3'b100;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick and blink

    reg  [31:0]        tick_cnt_reg;
    reg                tick_reg;
    reg  [`MS_W-1:0]   blink_cnt_reg;
    reg                blink_reg;

    always @(posedge MCLK) begin
        if (SRST) begin
            tick_cnt_reg  <= 32'h00000000;
            tick_reg      <= 1'b0;
            blink_cnt_reg <= {`MS_W{1'b0}};
            blink_reg     <= 1'b0;
        end else begin
            tick_reg <= (tick_cnt_reg == TICK_CYCLES - 1);
            if (tick_cnt_reg == TICK_CYCLES - 1)
                tick_cnt_reg <= 32'h00000000;
            else
                tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
            if (tick_reg) begin
                if (blink_cnt_reg == `BLINK_MS - 1) begin
                    blink_cnt_reg <= {`MS_W{1'b0}};
                    blink_reg     <= ~blink_reg; // R18
                end else begin
                    blink_cnt_reg <= blink_cnt_reg + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error and message state

    reg                err_act_reg;
    reg                err_lock_reg;
    reg  [1:0]         msg_src_reg;
    reg  [2:0]         msg_class_reg;
    reg  [11:0]        msg_code_reg;
    reg  [`MS_W-1:0]   rec_cnt_reg;
    reg  [1:0]         hold_reg;
    reg                recover_ev;
    wire               msg_is_err = MSG_SET & (MSG_CLASS != `CLS_I);
    wire [1:0]         fault;

    always @(posedge MCLK) begin
        if (SRST) begin
            err_act_reg   <= 1'b0;
            err_lock_reg  <= 1'b0; // R15
            msg_src_reg   <= `SRC_DEV;
            msg_class_reg <= `CLS_I;
            msg_code_reg  <= 12'h000;
            rec_cnt_reg   <= {`MS_W{1'b0}};
            hold_reg      <= 2'b00;
            recover_ev    <= 1'b0;
        end else begin
            recover_ev <= 1'b0;
            hold_reg   <= hold_reg & ~RES_UNLOCK;
            if (err_act_reg && !err_lock_reg && tick_reg) begin
                if (rec_cnt_reg == `RECOVER_MS - 1) begin
                    err_act_reg <= 1'b0; // R14
                    hold_reg    <= fault; // R14
                    recover_ev  <= 1'b1;
                    rec_cnt_reg <= {`MS_W{1'b0}};
                end else begin
                    rec_cnt_reg <= rec_cnt_reg + 1'b1;
                end
            end
            if (MSG_SET) begin
                msg_src_reg   <= MSG_SRC; // R11
                msg_class_reg <= MSG_CLASS;
                msg_code_reg  <= MSG_CODE;
            end
            if (msg_is_err) begin
                err_act_reg  <= 1'b1;
                rec_cnt_reg  <= {`MS_W{1'b0}};
                err_lock_reg <= err_lock_reg | MSG_LOCK; // R15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-function safety outputs and LEDs

    reg  [1:0] red_v;
    reg  [1:0] grn_v;
    reg  [1:0] yel_v;
    reg  [1:0] blu_v;
    reg  [31:0] ctrl_reg;

    genvar f;
    generate
        for (f = 0; f < 2; f = f + 1) begin : g_func
            assign fault[f] = err_act_reg &
                              ((msg_src_reg == f) | (msg_src_reg == `SRC_DEV));
            always @(posedge MCLK) begin
                if (SRST) begin
                    SOP_OUT[f] <= 1'b0;
                    red_v[f]   <= 1'b0;
                    grn_v[f]   <= 1'b0;
                    yel_v[f]   <= 1'b0;
                    blu_v[f]   <= 1'b0;
                end else begin
                    SOP_OUT[f] <= SOP_REQ[f] & ~PF_OCC[f] & ~fault[f] & ~hold_reg[f]; // R17
                    red_v[f]   <= fault[f] ? blink_reg : ~SOP_OUT[f]; // R2
                    grn_v[f]   <= ~fault[f] & SOP_OUT[f]; // R2
                    if (PF_OCC[f])
                        yel_v[f] <= blink_reg; // R3
                    else
                        yel_v[f] <= (RES_ACTIVE[f] & RES_READY[f]) | // R3
                                    (ctrl_reg[`CTRL_LINK_LSB + f] & LINK_ENABLED[f]); // R4
                    blu_v[f]   <= WF_OCC[f]; // R5
                end
            end
        end
    endgenerate

    always @* begin
        LED1_RED = red_v[0]; // R1
        LED1_GRN = grn_v[0];
        LED2     = yel_v[0];
        LED3     = blu_v[0];
        LED4     = blu_v[1]; // R1
        LED5     = yel_v[1];
        LED6_RED = red_v[1];
        LED6_GRN = grn_v[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // Display mode machine

    reg  [2:0]       state_reg;
    reg  [3:0]       item_reg;
    reg  [`MS_W-1:0] item_cnt_reg;
    reg  [`MS_W-1:0] free_cnt_reg;
    reg              ping_view_reg;
    reg              boot_d_reg;
    wire             view_ev = MSG_SET | PING;
    wire [3:0]       last_item = CFG_STORED ? `SCR_TILT : `SCR_NEEDED;

    always @(posedge MCLK) begin
        if (SRST) begin
            state_reg     <= ST_BOOT;
            item_reg      <= `SCR_TYPE;
            item_cnt_reg  <= {`MS_W{1'b0}};
            free_cnt_reg  <= {`MS_W{1'b0}};
            ping_view_reg <= 1'b0;
            boot_d_reg    <= 1'b0;
        end else begin
            boot_d_reg <= BOOTING;
            if (tick_reg)
                item_cnt_reg <= (item_cnt_reg == `ITEM_MS - 1) ? {`MS_W{1'b0}} :
                                item_cnt_reg + 1'b1;
            if (|PF_OCC)
                free_cnt_reg <= {`MS_W{1'b0}};
            else if (tick_reg && free_cnt_reg != `FREE_MS)
                free_cnt_reg <= free_cnt_reg + 1'b1;
            case (state_reg)
                ST_BOOT: begin
                    if (tick_reg && item_cnt_reg == `ITEM_MS - 1) begin
                        if (item_reg == last_item)
                            item_reg <= `SCR_TYPE; // R7 R8
                        else if (item_reg == `SCR_WIRELESS)
                            item_reg <= CFG_STORED ? `SCR_DATE : `SCR_NEEDED; // R7 R8
                        else
                            item_reg <= item_reg + 4'h1;
                    end
                    if (!BOOTING)
                        state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (view_ev) begin
                        state_reg    <= ST_VIEW;
                        free_cnt_reg <= {`MS_W{1'b0}};
                    end
                end
                ST_VIEW: begin
                    if (view_ev)
                        free_cnt_reg <= {`MS_W{1'b0}};
                    else if (free_cnt_reg == `FREE_MS)
                        state_reg <= ST_RUN; // R16
                end
                default: state_reg <= ST_BOOT;
            endcase
            if (PING)
                ping_view_reg <= 1'b1;
            else if (MSG_SET)
                ping_view_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display text

    reg  [7:0]   cls_ch;
    reg  [7:0]   src_ch;
    reg  [3:0]   scr_v;
    reg  [191:0] txt_v;

    always @* begin
        case (msg_class_reg)
            `CLS_F:  cls_ch = `CH_F; // R12
            `CLS_E:  cls_ch = `CH_E;
            `CLS_U:  cls_ch = `CH_U;
            `CLS_P:  cls_ch = `CH_P;
            default: cls_ch = `CH_I;
        endcase
        case (msg_src_reg)
            `SRC_A:  src_ch = `CH_A;
            `SRC_B:  src_ch = `CH_B;
            default: src_ch = `CH_D;
        endcase
        scr_v = `SCR_BLANK;
        txt_v = {24{`CH_SP}};
        if (!ctrl_reg[`CTRL_DISP_EN]) begin
            scr_v = `SCR_BLANK;
        end else if (CFG_XFER) begin
            scr_v = `SCR_XFER;
            txt_v = `TXT_XFER; // R9
        end else if (CFG_WAIT) begin
            scr_v = `SCR_WAIT;
            txt_v = `TXT_WAIT; // R9
        end else if (state_reg == ST_VIEW && ping_view_reg) begin
            scr_v = `SCR_PING;
            txt_v = {`TXT_PING, SRC_TEXT[191:40]}; // R10
        end else if (state_reg == ST_VIEW) begin
            scr_v = `SCR_VIEW;
            txt_v = {src_ch, `CH_COLON, cls_ch, // R13
                     `CH_ZERO + {4'h0, msg_code_reg[11:8]},
                     `CH_ZERO + {4'h0, msg_code_reg[7:4]},
                     `CH_ZERO + {4'h0, msg_code_reg[3:0]}, {18{`CH_SP}}};
        end else if (state_reg == ST_BOOT) begin
            scr_v = item_reg;
            txt_v = (item_reg == `SCR_NEEDED) ? `TXT_NEEDED : SRC_TEXT; // R7
        end else begin
            scr_v = CFG_STORED ? `SCR_FIELD : `SCR_TILT; // R6 R7 R8
            txt_v = SRC_TEXT;
        end
    end

    always @(posedge MCLK) begin
        if (SRST) begin
            DISP_SCREEN <= `SCR_BLANK;
            DISP_TEXT   <= {24{`CH_SP}};
        end else begin
            DISP_SCREEN <= scr_v;
            DISP_TEXT   <= txt_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB registers and interrupt

    reg  [`EV_W-1:0] status_reg;
    reg  [`EV_W-1:0] mask_reg;
    wire [`EV_W-1:0] ev;
    wire             wr_acc = PSEL & PENABLE & PWRITE;
    reg              hit;

    assign ev[`EV_ERR]       = msg_is_err;
    assign ev[`EV_MSG]       = MSG_SET & ~msg_is_err;
    assign ev[`EV_RECOVER]   = recover_ev;
    assign ev[`EV_PING]      = PING;
    assign ev[`EV_BOOT_DONE] = boot_d_reg & ~BOOTING;
    assign PREADY            = 1'b1;
    assign PSLVERR           = PSEL & PENABLE & ~hit;

    always @* begin
        case (PADDR)
            `ADDR_CTRL, `ADDR_STATUS, `ADDR_MASK,
            `ADDR_STATE, `ADDR_ERRINFO: hit = 1'b1;
            default:                    hit = 1'b0;
        endcase
    end

    always @(posedge MCLK) begin
        if (SRST) begin
            ctrl_reg   <= `CTRL_RST;
            status_reg <= {`EV_W{1'b0}};
            mask_reg   <= {`EV_W{1'b0}};
            PRDATA     <= 32'h00000000;
            IRQ        <= 1'b0;
        end else begin
            if (wr_acc && PADDR == `ADDR_CTRL)
                ctrl_reg <= {29'h00000000, PWDATA[2:0]};
            if (wr_acc && PADDR == `ADDR_MASK)
                mask_reg <= PWDATA[`EV_W-1:0];
            if (wr_acc && PADDR == `ADDR_STATUS)
                status_reg <= (status_reg & ~PWDATA[`EV_W-1:0]) | ev;
            else
                status_reg <= status_reg | ev;
            IRQ <= |(status_reg & mask_reg);
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    `ADDR_CTRL:    PRDATA <= ctrl_reg;
                    `ADDR_STATUS:  PRDATA <= {27'h0000000, status_reg};
                    `ADDR_MASK:    PRDATA <= {27'h0000000, mask_reg};
                    `ADDR_STATE:   PRDATA <= {19'h00000, SOP_OUT, hold_reg,
                                              err_lock_reg, err_act_reg,
                                              state_reg, DISP_SCREEN};
                    `ADDR_ERRINFO: PRDATA <= {15'h0000, msg_src_reg,
                                              msg_class_reg, msg_code_reg};
                    default:       PRDATA <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

/* File: verif/status_indicator_assertions.sv */
// Port-level property checker for the scanner status indicator
module status_indicator_assertions #(
    parameter TICK_CYCLES = 2
) (
    input wire        MCLK,
    input wire        SRST,
    input wire        PSEL,
    input wire        PENABLE,
    input wire [11:0] PADDR,
    input wire        PSLVERR,
    input wire [1:0]  SOP_REQ,
    input wire [1:0]  PF_OCC,
    input wire [1:0]  WF_OCC,
    input wire [1:0]  RES_ACTIVE,
    input wire [1:0]  RES_READY,
    input wire [1:0]  LINK_ENABLED,
    input wire [1:0]  SOP_OUT,
    input wire        LED1_RED,
    input wire        LED1_GRN,
    input wire        LED2,
    input wire        LED3,
    input wire        LED4,
    input wire        LED6_RED,
    input wire        LED6_GRN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////////////////////////
    a_field_drops_a: assert property (PF_OCC[0] |=> !SOP_OUT[0])
        else $error("Output pair A stayed on with field occupied");
    a_field_drops_b: assert property (PF_OCC[1] |=> !SOP_OUT[1])
        else $error("Output pair B stayed on with field occupied");
    a_sop_needs_req: assert property (SOP_OUT[0] |-> $past(SOP_REQ[0]) && !$past(PF_OCC[0]))
        else $error("Output pair A on without request");
    a_green_own_sop: assert property (LED1_GRN |-> !LED1_RED && $past(SOP_OUT[0]))
        else $error("LED1 green without output pair A");
    a_green_b_sop: assert property (LED6_GRN |-> !LED6_RED && $past(SOP_OUT[1]))
        else $error("LED6 green without output pair B");
    a_blue_on_a: assert property (WF_OCC[0] [*3] |-> LED3)
        else $error("LED3 dark with warning field A interrupted");
    a_blue_off_a: assert property (!WF_OCC[0] [*3] |-> !LED3)
        else $error("LED3 lit with warning field A free");
    a_blue_on_b: assert property (WF_OCC[1] [*3] |-> LED4)
        else $error("LED4 dark with warning field B interrupted");
    a_yellow_ready: assert property
        ((!PF_OCC[0] && RES_ACTIVE[0] && RES_READY[0]) [*3] |-> LED2)
        else $error("LED2 dark with interlock ready");
    a_yellow_dark: assert property
        ((!PF_OCC[0] && !RES_ACTIVE[0] && !LINK_ENABLED[0]) [*3] |-> !LED2)
        else $error("LED2 lit with interlock off");
    a_unmapped_err: assert property (PSEL && PENABLE && PADDR > 12'h010 |-> PSLVERR)
        else $error("No bus error on unmapped address");
endmodule

/* File: verif/operator_view.sv */
// Operator model: watches one lamp and reports its last steady interval
module operator_view (
    input  wire         MCLK,
    input  wire         LAMP,
    output logic [15:0] HALF_PERIOD
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_reg = 16'h0000;
    logic        last_reg = 1'b0;
    always @(posedge MCLK) begin
        last_reg <= LAMP;
        if (LAMP !== last_reg) begin
            HALF_PERIOD <= cnt_reg + 16'h0001;
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

/* File: verif/scanner_status_indicator_tb_top.sv */
// Testbench for the scanner status indicator
`include "indicator_map.vh"
module scanner_status_indicator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000, MSG_CODE = 12'h000;
    logic [31:0] PWDATA = 32'h0, q;
    logic [1:0] SOP_REQ = 2'h3, PF_OCC = 2'h0, WF_OCC = 2'h0, RES_ACTIVE = 2'h0;
    logic [1:0] RES_READY = 2'h0, RES_UNLOCK = 2'h0, LINK_ENABLED = 2'h0, MSG_SRC = 2'h0;
    logic BOOTING = 1'b1, CFG_STORED = 1'b0, CFG_WAIT = 1'b0, CFG_XFER = 1'b0;
    logic PING = 1'b0, MSG_SET = 1'b0, MSG_LOCK = 1'b0, e;
    logic [2:0] MSG_CLASS = 3'h0;
    logic [191:0] SRC_TEXT = "SCANNER UNIT 0042       ";
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, IRQ, LED1_RED, LED1_GRN, LED2, LED3, LED4, LED5, LED6_RED, LED6_GRN;
    wire [1:0] SOP_OUT;
    wire [3:0] DISP_SCREEN;
    wire [191:0] DISP_TEXT;
    wire [15:0] red_half, yel_half;
    int fail_count = 0, num_checks = 0, cyc = 0, ncyc = 0;
    logic [7:0] cls_txt [5] = '{"F", "E", "U", "I", "P"};
    status_indicator #(.TICK_CYCLES(2)) u_status_indicator (
        .MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IRQ(IRQ), .SOP_REQ(SOP_REQ), .PF_OCC(PF_OCC),
        .WF_OCC(WF_OCC), .RES_ACTIVE(RES_ACTIVE), .RES_READY(RES_READY),
        .RES_UNLOCK(RES_UNLOCK), .LINK_ENABLED(LINK_ENABLED), .BOOTING(BOOTING),
        .CFG_STORED(CFG_STORED), .CFG_WAIT(CFG_WAIT), .CFG_XFER(CFG_XFER), .PING(PING),
        .MSG_SET(MSG_SET), .MSG_SRC(MSG_SRC), .MSG_CLASS(MSG_CLASS), .MSG_CODE(MSG_CODE),
        .MSG_LOCK(MSG_LOCK), .SRC_TEXT(SRC_TEXT), .SOP_OUT(SOP_OUT), .LED1_RED(LED1_RED),
        .LED1_GRN(LED1_GRN), .LED2(LED2), .LED3(LED3), .LED4(LED4), .LED5(LED5),
        .LED6_RED(LED6_RED), .LED6_GRN(LED6_GRN), .DISP_SCREEN(DISP_SCREEN),
        .DISP_TEXT(DISP_TEXT));
    operator_view u_operator_view (.MCLK(MCLK), .LAMP(LED1_RED), .HALF_PERIOD(red_half));
    operator_view u_operator_view_y (.MCLK(MCLK), .LAMP(LED2), .HALF_PERIOD(yel_half));
    ////////////////////////////////////////////////////////////
    always #5 MCLK = ~MCLK;
    always @(posedge MCLK) cyc <= SRST ? 0 : cyc + 1;
    always @(posedge MCLK) begin
        ncyc <= ncyc + 1;
        if (ncyc == 95000) begin
            fail_count++;
            $display("ERROR %0t: run timed out", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [191:0] g, input logic [191:0] x);
        num_checks++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t: got %0h expected %0h", $time, g, x);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        tick(1);
        PENABLE <= 1'b1;
        tick(1);
        while (PREADY !== 1'b1) begin
            tick(1);
        end
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic leds(input logic [7:0] x);
        chk({LED1_RED, LED1_GRN, LED2, LED3, LED4, LED5, LED6_RED, LED6_GRN}, x);
    endtask
    task automatic msg(input logic [1:0] s, input logic [2:0] c, input logic [11:0] k,
                       input logic l);
        MSG_SET <= 1'b1;
        MSG_SRC <= s;
        MSG_CLASS <= c;
        MSG_CODE <= k;
        MSG_LOCK <= l;
        tick(1);
        MSG_SET <= 1'b0;
        tick(3);
        chk(DISP_SCREEN, `SCR_VIEW);
    endtask
    task automatic boot(input logic [39:0] seq);
        for (int i = 0; i < 10; i++) begin
            while (cyc < 1000 + 2000 * i) tick(1);
            chk(DISP_SCREEN, seq[39 - 4 * i -: 4]);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        SRST <= 1'b0;
        tick(2);
        rd(`ADDR_CTRL, 32'h1);
        rd(`ADDR_STATUS, 32'h0);
        apb(1'b1, `ADDR_MASK, 32'h1F);
        rd(`ADDR_MASK, 32'h1F);
        rd(12'h014, 32'h0);
        chk(e, 1'b1);
        $display("test registers done");
        boot(40'h0123456012);
        BOOTING <= 1'b0;
        tick(10);
        chk(DISP_SCREEN, `SCR_TILT);
        chk(IRQ, 1'b1);
        rd(`ADDR_STATUS, 32'h10);
        apb(1'b1, `ADDR_STATUS, 32'h10);
        tick(3);
        chk(IRQ, 1'b0);
        apb(1'b1, `ADDR_MASK, 32'h0);
        $display("test boot done");
        leds(8'h41);
        PF_OCC <= 2'h1;
        WF_OCC <= 2'h2;
        tick(1100);
        chk(SOP_OUT, 2'b10);
        chk({LED1_RED, LED1_GRN, LED4, LED3, LED6_GRN}, 5'b10101);
        chk(yel_half, 16'h01F4);
        PF_OCC <= 2'h0;
        WF_OCC <= 2'h0;
        RES_ACTIVE <= 2'h1;
        RES_READY <= 2'h1;
        tick(4);
        leds(8'h61);
        RES_ACTIVE <= 2'h0;
        apb(1'b1, `ADDR_CTRL, 32'h3);
        LINK_ENABLED <= 2'h1;
        tick(4);
        leds(8'h61);
        LINK_ENABLED <= 2'h0;
        tick(4);
        leds(8'h41);
        $display("test leds done");
        for (int i = 0; i < 5; i++) begin
            msg(`SRC_A, 3'(i), 12'h123, 1'b0);
            chk(DISP_TEXT[191:144], {"A:", cls_txt[i], "123"});
        end
        rd(`ADDR_ERRINFO, {15'h0000, 2'h0, 3'h4, 12'h123});
        rd(`ADDR_STATUS, 32'h3);
        apb(1'b1, `ADDR_MASK, 32'h3);
        tick(3);
        chk(IRQ, 1'b1);
        apb(1'b1, `ADDR_STATUS, 32'h3);
        tick(3);
        chk(IRQ, 1'b0);
        tick(9000);
        chk(DISP_SCREEN, `SCR_VIEW);
        chk({red_half, LED6_GRN}, {16'h01F4, 1'b1});
        tick(2000);
        chk(DISP_SCREEN, `SCR_TILT);
        tick(9500);
        rd(`ADDR_STATUS, 32'h4);
        chk({SOP_OUT, LED1_RED, LED1_GRN}, 4'b1010);
        RES_UNLOCK <= 2'h1;
        tick(1);
        RES_UNLOCK <= 2'h0;
        tick(4);
        chk(SOP_OUT, 2'b11);
        leds(8'h41);
        $display("test messages done");
        msg(`SRC_DEV, `CLS_F, 12'h007, 1'b1);
        chk(DISP_TEXT[191:144], "D:F007");
        tick(20500);
        apb(1'b0, `ADDR_STATE, 32'h0);
        chk({q[8], LED1_GRN, LED6_GRN}, 3'b100);
        CFG_STORED <= 1'b1;
        BOOTING <= 1'b1;
        SRST <= 1'b1;
        tick(8);
        SRST <= 1'b0;
        tick(2);
        apb(1'b0, `ADDR_STATE, 32'h0);
        chk(q[8], 1'b0);
        $display("test lock done");
        boot(40'h0123457890);
        BOOTING <= 1'b0;
        tick(10);
        chk(DISP_SCREEN, `SCR_FIELD);
        CFG_WAIT <= 1'b1;
        tick(4);
        chk(DISP_SCREEN, `SCR_WAIT);
        CFG_XFER <= 1'b1;
        tick(4);
        chk(DISP_SCREEN, `SCR_XFER);
        CFG_WAIT <= 1'b0;
        CFG_XFER <= 1'b0;
        PING <= 1'b1;
        tick(1);
        PING <= 1'b0;
        tick(4);
        chk(DISP_SCREEN, `SCR_PING);
        chk(DISP_TEXT, {"PING ", SRC_TEXT[191:40]});
        $display("test config done");
        test_done();
    end
endmodule
bind status_indicator status_indicator_assertions #(.TICK_CYCLES(TICK_CYCLES))
    u_status_indicator_assertions (
    .MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
    .PSLVERR(PSLVERR), .SOP_REQ(SOP_REQ), .PF_OCC(PF_OCC), .WF_OCC(WF_OCC),
    .RES_ACTIVE(RES_ACTIVE), .RES_READY(RES_READY), .LINK_ENABLED(LINK_ENABLED),
    .SOP_OUT(SOP_OUT), .LED1_RED(LED1_RED), .LED1_GRN(LED1_GRN), .LED2(LED2),
    .LED3(LED3), .LED4(LED4), .LED6_RED(LED6_RED), .LED6_GRN(LED6_GRN));
